// file: usbie_irq_enables.sv
// usbie_irq_enables: usb interrupt enable masks, pending flags and request, apb slave
//
// Contract
// - in enable bit1 ep1, bit0 ep0, reset 03
// - out enable bit1 ep1 interrupt, reset 02
// - common enable upper nibble reads zero, ignored
// - common bit3 enables start-of-frame interrupt
// - common bit2 enables bus-reset interrupt
// - common bit1 enables resume interrupt
// - common bit0 enables suspend interrupt
// - common enable resets to 06
// - each enable gates its hardware-set pending flag
module usbie_irq_enables (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [usbie_pkg::ADDR_W-1:0] paddr,
  input  wire logic [usbie_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  input  wire usbie_pkg::usbie_evt_t      evt,
  output logic      [usbie_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq
);
  import usbie_pkg::*;

  localparam int FW = REG_W * NFLAG_R;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] i);
    return a == {i, 2'b00};
  endfunction

  logic [REG_W-1:0] in_endpoint_irq_enable;
  logic [REG_W-1:0] out_endpoint_irq_enable;
  logic [REG_W-1:0] common_bus_irq_enable;
  logic [FW-1:0]    flags_q;

  wire setup = psel & ~penable;
  wire done  = psel & penable & pready;

  wire hit_in_flg  = hit(paddr, IDX_IN_FLAGS);
  wire hit_out_flg = hit(paddr, IDX_OUT_FLAGS);
  wire hit_cmn_flg = hit(paddr, IDX_CMN_FLAGS);
  wire hit_in_en   = hit(paddr, IDX_IN_EN);
  wire hit_out_en  = hit(paddr, IDX_OUT_EN);
  wire hit_cmn_en  = hit(paddr, IDX_CMN_EN);
  wire mapped      = hit_in_flg | hit_out_flg | hit_cmn_flg | hit_in_en | hit_out_en | hit_cmn_en;

  // only lane 0 carries the byte-wide registers
  wire wr = done & pwrite & pstrb[0] & mapped;
  wire rd = done & ~pwrite;

  wire [REG_W-1:0] in_flg  = flags_q[LO_IN +: REG_W];
  wire [REG_W-1:0] out_flg = flags_q[LO_OUT +: REG_W];
  wire [REG_W-1:0] cmn_flg = flags_q[LO_CMN +: REG_W];

  wire [REG_W-1:0] rd_byte =
    hit_in_flg  ? in_flg  :
    hit_out_flg ? out_flg :
    hit_cmn_flg ? cmn_flg :
    hit_in_en   ? in_endpoint_irq_enable  :
    hit_out_en  ? out_endpoint_irq_enable :
    hit_cmn_en  ? common_bus_irq_enable   : '0;
  wire [DATA_W-1:0] rd_word = {{(DATA_W-REG_W){1'b0}}, rd_byte};

  // unused bits are masked on the way in so they always read back zero
  wire [REG_W-1:0] next_in_en  = (wr & hit_in_en)  ? (pwdata[REG_W-1:0] & MASK_IN)
                                                   : in_endpoint_irq_enable;
  wire [REG_W-1:0] next_out_en = (wr & hit_out_en) ? (pwdata[REG_W-1:0] & MASK_OUT)
                                                   : out_endpoint_irq_enable;
  wire [REG_W-1:0] next_cmn_en = (wr & hit_cmn_en) ? (pwdata[REG_W-1:0] & MASK_CMN)
                                                   : common_bus_irq_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_endpoint_irq_enable  <= RST_IN_EN;
      out_endpoint_irq_enable <= RST_OUT_EN;
      common_bus_irq_enable   <= RST_CMN_EN;
    end else begin
      in_endpoint_irq_enable  <= next_in_en;
      out_endpoint_irq_enable <= next_out_en;
      common_bus_irq_enable   <= next_cmn_en;
    end
  end

  // hardware events into flag lanes
  logic [REG_W-1:0] set_in;
  logic [REG_W-1:0] set_out;
  logic [REG_W-1:0] set_cmn;
  always_comb begin
    set_in  = '0;
    set_out = '0;
    set_cmn = '0;
    set_in[BIT_EP0]   = evt.control_ep;
    set_in[BIT_IN1]   = evt.in_ep1;
    set_out[BIT_OUT1] = evt.out_ep1;
    set_cmn[BIT_SOF]  = evt.frame_start;
    set_cmn[BIT_RST]  = evt.bus_reset;
    set_cmn[BIT_RSU]  = evt.resume;
    set_cmn[BIT_SUS]  = evt.suspend;
  end

  // a read clears only the bits it returned; a flag set after the data
  // was captured survives for the next read
  wire [REG_W-1:0] cap = prdata[REG_W-1:0];
  wire [FW-1:0] flag_set = {set_cmn, set_out, set_in};
  wire [FW-1:0] flag_clr = {(rd & hit_cmn_flg) ? cap : {REG_W{1'b0}},
                            (rd & hit_out_flg) ? cap : {REG_W{1'b0}},
                            (rd & hit_in_flg)  ? cap : {REG_W{1'b0}}};

  usbie_flags #(
    .W (FW)
  ) u_flags (
    .clk   (pclk),
    .rst_n (presetn),
    .set   (flag_set),
    .clr   (flag_clr),
    .q     (flags_q)
  );

  wire [FW-1:0] en_all = {common_bus_irq_enable, out_endpoint_irq_enable, in_endpoint_irq_enable};
  wire          req    = |(flags_q & en_all);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= req;
  end

  // zero wait states: answer is ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) prdata <= pwrite ? '0 : rd_word;
    end
  end

  // checks
  property p_in_en_write;
    @(posedge pclk) disable iff (!presetn)
    (wr & hit_in_en) |=> (in_endpoint_irq_enable == ($past(pwdata[REG_W-1:0]) & MASK_IN))
      && ((in_endpoint_irq_enable & ~MASK_IN) == '0);
  endproperty
  a_in_en_write: assert property (p_in_en_write) else $error("in enable write wrong");

  property p_out_en_write;
    @(posedge pclk) disable iff (!presetn)
    (wr & hit_out_en) |=> out_endpoint_irq_enable == ($past(pwdata[REG_W-1:0]) & MASK_OUT);
  endproperty
  a_out_en_write: assert property (p_out_en_write) else $error("out enable write wrong");

  property p_cmn_upper_zero;
    @(posedge pclk) disable iff (!presetn)
    (setup & ~pwrite & hit_cmn_en) |=> prdata[REG_W-1:4] == '0;
  endproperty
  a_cmn_upper_zero: assert property (p_cmn_upper_zero) else $error("upper nibble not zero");

  property p_sof_gate;
    @(posedge pclk) disable iff (!presetn)
    (cmn_flg[BIT_SOF] & common_bus_irq_enable[BIT_SOF]) |=> irq;
  endproperty
  a_sof_gate: assert property (p_sof_gate) else $error("sof request missing");

  property p_rst_gate;
    @(posedge pclk) disable iff (!presetn)
    evt.bus_reset ##1 common_bus_irq_enable[BIT_RST] |=> irq;
  endproperty
  a_rst_gate: assert property (p_rst_gate) else $error("bus reset request missing");

  property p_rsu_gate;
    @(posedge pclk) disable iff (!presetn)
    (cmn_flg == (8'h01 << BIT_RSU)) && (en_all & flags_q) == '0 |=> !irq;
  endproperty
  a_rsu_gate: assert property (p_rsu_gate) else $error("masked resume raised request");

  property p_sus_gate;
    @(posedge pclk) disable iff (!presetn)
    (cmn_flg[BIT_SUS] & common_bus_irq_enable[BIT_SUS]) |=> irq;
  endproperty
  a_sus_gate: assert property (p_sus_gate) else $error("suspend request missing");

  property p_cmn_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> common_bus_irq_enable == RST_CMN_EN && in_endpoint_irq_enable == RST_IN_EN;
  endproperty
  a_cmn_reset: assert property (p_cmn_reset) else $error("enable reset value wrong");

  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
    evt.bus_reset || (cmn_flg[BIT_RST] && !(rd && hit_cmn_flg && cap[BIT_RST]))
      |=> cmn_flg[BIT_RST];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("pending flag lost");

  property p_irq_drop;
    @(posedge pclk) disable iff (!presetn)
    !req |=> !irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("request held without cause");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer timing wrong");

  property p_no_wait;
    @(posedge pclk) disable iff (!presetn)
    (psel & penable) |-> pready;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("access phase without ready");

  property p_err_unmapped;
    @(posedge pclk) disable iff (!presetn)
    done |-> (pslverr == ~mapped);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("error response wrong");

  property p_rd_upper_zero;
    @(posedge pclk) disable iff (!presetn)
    pready |-> (prdata[DATA_W-1:REG_W] == '0);
  endproperty
  a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("read data upper bits set");

  property p_ep0_gate;
    @(posedge pclk) disable iff (!presetn)
    (in_flg[BIT_EP0] & in_endpoint_irq_enable[BIT_EP0]) |=> irq;
  endproperty
  a_ep0_gate: assert property (p_ep0_gate) else $error("ep0 request missing");

  property p_in1_gate;
    @(posedge pclk) disable iff (!presetn)
    (in_flg[BIT_IN1] & in_endpoint_irq_enable[BIT_IN1]) |=> irq;
  endproperty
  a_in1_gate: assert property (p_in1_gate) else $error("in ep1 request missing");

  property p_out1_gate;
    @(posedge pclk) disable iff (!presetn)
    (out_flg[BIT_OUT1] & out_endpoint_irq_enable[BIT_OUT1]) |=> irq;
  endproperty
  a_out1_gate: assert property (p_out1_gate) else $error("out ep1 request missing");

  property p_out_unused;
    @(posedge pclk) disable iff (!presetn)
    (out_endpoint_irq_enable & ~MASK_OUT) == '0;
  endproperty
  a_out_unused: assert property (p_out_unused) else $error("out unused bit set");

  property p_cmn_write;
    @(posedge pclk) disable iff (!presetn)
    (wr & hit_cmn_en) |=> common_bus_irq_enable == ($past(pwdata[REG_W-1:0]) & MASK_CMN);
  endproperty
  a_cmn_write: assert property (p_cmn_write) else $error("common enable write wrong");

  property p_cmn_unused;
    @(posedge pclk) disable iff (!presetn)
    (common_bus_irq_enable & ~MASK_CMN) == '0;
  endproperty
  a_cmn_unused: assert property (p_cmn_unused) else $error("common upper bit set");

  property p_en_hold;
    @(posedge pclk) disable iff (!presetn)
    !wr |=> $stable(in_endpoint_irq_enable) && $stable(out_endpoint_irq_enable)
      && $stable(common_bus_irq_enable);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable changed without write");

  property p_irq_rise;
    @(posedge pclk) disable iff (!presetn)
    req |=> irq;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("request not raised");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
    (rd & hit_cmn_flg & cap[BIT_RST] & ~evt.bus_reset) |=> !cmn_flg[BIT_RST];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("read did not clear flag");

  property p_set_visible;
    @(posedge pclk) disable iff (!presetn)
    (|flag_set) |=> ((flags_q & $past(flag_set)) == $past(flag_set));
  endproperty
  a_set_visible: assert property (p_set_visible) else $error("event flag not set");

  property p_wr_keeps;
    @(posedge pclk) disable iff (!presetn)
    (done & pwrite) |=> ((flags_q & $past(flags_q)) == $past(flags_q));
  endproperty
  a_wr_keeps: assert property (p_wr_keeps) else $error("write cleared a flag");

  property p_out_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> out_endpoint_irq_enable == RST_OUT_EN && !irq && flags_q == '0;
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("reset state wrong");

  c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_cmn_write: cover property (@(posedge pclk) disable iff (!presetn) wr & hit_cmn_en);
  c_flag_clear: cover property (@(posedge pclk) disable iff (!presetn) rd & hit_cmn_flg & |cap);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) done & pslverr);
  c_irq_fall: cover property (@(posedge pclk) disable iff (!presetn) $fell(irq));
endmodule // usbie_irq_enables

// file: usbie_pkg.sv
// usbie_pkg: register map, field layout and reset values of the usb interrupt enable block
package usbie_pkg;
  localparam int IDX_W   = 6;
  localparam int ADDR_W  = IDX_W + 2;
  localparam int DATA_W  = 32;
  localparam int REG_W   = 8;
  localparam int NFLAG_R = 3;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_IN_FLAGS  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_OUT_FLAGS = 6'h04;
  localparam logic [IDX_W-1:0] IDX_CMN_FLAGS = 6'h06;
  localparam logic [IDX_W-1:0] IDX_IN_EN     = 6'h07;
  localparam logic [IDX_W-1:0] IDX_OUT_EN    = 6'h09;
  localparam logic [IDX_W-1:0] IDX_CMN_EN    = 6'h0b;

  localparam logic [REG_W-1:0] RST_IN_EN  = 8'h03;
  localparam logic [REG_W-1:0] RST_OUT_EN = 8'h02;
  localparam logic [REG_W-1:0] RST_CMN_EN = 8'h06;

  // implemented bits; all others read zero and ignore writes
  localparam logic [REG_W-1:0] MASK_IN  = 8'h03;
  localparam logic [REG_W-1:0] MASK_OUT = 8'h02;
  localparam logic [REG_W-1:0] MASK_CMN = 8'h0f;

  localparam int BIT_EP0  = 0;
  localparam int BIT_IN1  = 1;
  localparam int BIT_OUT1 = 1;
  localparam int BIT_SUS  = 0;
  localparam int BIT_RSU  = 1;
  localparam int BIT_RST  = 2;
  localparam int BIT_SOF  = 3;

  // lanes of the packed flag and enable vectors
  localparam int LO_IN  = 0;
  localparam int LO_OUT = 8;
  localparam int LO_CMN = 16;

  typedef struct packed {
    logic frame_start;
    logic bus_reset;
    logic resume;
    logic suspend;
    logic out_ep1;
    logic in_ep1;
    logic control_ep;
  } usbie_evt_t;
endpackage

// file: usbie_flags.sv
// usbie_flags: sticky pending flags, set by hardware events, cleared by software reads
module usbie_flags #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      // set beats clear so an event in the clearing cycle is kept
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) q[i] <= 1'b0;
        else q[i] <= set[i] | (q[i] & ~clr[i]);
      end
    end
  endgenerate
endmodule // usbie_flags

// file: usbie_cpu_model.sv
// usbie_cpu_model: processor side model issuing apb register transfers
module usbie_cpu_model (
  input  wire logic                         pclk,
  input  wire logic [usbie_pkg::DATA_W-1:0] prdata,
  input  wire logic                         pready,
  input  wire logic                         pslverr,
  output logic                              psel,
  output logic                              penable,
  output logic                              pwrite,
  output logic      [usbie_pkg::ADDR_W-1:0] paddr,
  output logic      [usbie_pkg::DATA_W-1:0] pwdata,
  output logic      [3:0]                   pstrb
);
  timeunit 1ns;
  timeprecision 1ps;
  import usbie_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
  end
  // one transfer; the wait is cut short only by the bench timeout
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show garbage, not the last value
    paddr <= ~a;
    pwdata <= ~d;
    pstrb <= ~s;
  endtask
endmodule // usbie_cpu_model

// file: usbie_irq_enables_bench.sv
// usbie_irq_enables_bench: self-checking bench of the usb interrupt enable block
module usbie_irq_enables_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import usbie_pkg::*;
  logic pclk = 1'b0;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [3:0] pstrb;
  usbie_evt_t evt;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] q;
  logic e;
  always #5 pclk = ~pclk;
  usbie_irq_enables usbie_irq_enables_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .evt(evt), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  usbie_cpu_model usbie_cpu_model_inst (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic x;
    usbie_cpu_model_inst.xfer(1'b1, {i, 2'b00}, d, s, r, x);
  endtask
  task automatic rd(input logic [IDX_W-1:0] i);
    usbie_cpu_model_inst.xfer(1'b0, {i, 2'b00}, 32'h0, 4'hf, q, e);
  endtask
  // one pulse of a single event, then let the flag land
  task automatic pulse(input int i);
    @(posedge pclk);
    evt <= usbie_evt_t'(7'h01 << i);
    @(posedge pclk);
    evt <= '0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_reset();
    chk(irq, 0);
    rd(IDX_IN_EN);
    chk(q, 32'h03);
    rd(IDX_OUT_EN);
    chk(q, 32'h02);
    rd(IDX_CMN_EN);
    chk(q, 32'h06);
    pulse(5);
    chk(irq, 1);
    rd(IDX_CMN_FLAGS);
    chk(q, 32'h04);
    $display("t_reset done");
  endtask
  task automatic t_regs();
    wr(IDX_IN_EN, 32'hff, 4'hf);
    rd(IDX_IN_EN);
    chk(q, 32'h03);
    wr(IDX_OUT_EN, 32'hff, 4'hf);
    rd(IDX_OUT_EN);
    chk(q, 32'h02);
    wr(IDX_CMN_EN, 32'hff, 4'hf);
    rd(IDX_CMN_EN);
    chk(q, 32'h0f);
    // strobe low must leave the register alone
    wr(IDX_CMN_EN, 32'h00, 4'h0);
    rd(IDX_CMN_EN);
    chk(q, 32'h0f);
    // flag registers are read-only
    wr(IDX_CMN_FLAGS, 32'hff, 4'hf);
    rd(IDX_CMN_FLAGS);
    chk(q, 32'h00);
    rd(6'h3f);
    chk({q[30:0], e}, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_irq();
    logic [IDX_W-1:0] en_i [7] = '{IDX_IN_EN, IDX_IN_EN, IDX_OUT_EN,
                                   IDX_CMN_EN, IDX_CMN_EN, IDX_CMN_EN, IDX_CMN_EN};
    logic [IDX_W-1:0] fl_i [7] = '{IDX_IN_FLAGS, IDX_IN_FLAGS, IDX_OUT_FLAGS,
                                   IDX_CMN_FLAGS, IDX_CMN_FLAGS, IDX_CMN_FLAGS, IDX_CMN_FLAGS};
    int eb [7] = '{0, 1, 1, 0, 1, 2, 3};
    for (int i = 0; i < 7; i++) begin
      wr(IDX_IN_EN, 32'h0, 4'hf);
      wr(IDX_OUT_EN, 32'h0, 4'hf);
      wr(IDX_CMN_EN, 32'h0, 4'hf);
      pulse(i);
      chk(irq, 0);
      wr(en_i[i], 32'h1 << eb[i], 4'hf);
      repeat (2) @(posedge pclk);
      chk(irq, 1);
      rd(fl_i[i]);
      chk(q, 32'h1 << eb[i]);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
    end
    $display("t_irq done");
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    presetn = 1'b0;
    evt = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_irq();
    tally_and_finish();
  end
endmodule // usbie_irq_enables_bench
